/* File: logic/mptc_timer_control.sv */
// control, status and up/down counter of the single channel motor pwm timer
//
// Summary of operation
// R1 - mode register clears on reset or standby, keeps value in module standby.
// R2 - mode bit 3 selects negative phase active level, 0 low, 1 high.
// R3 - mode bit 2 selects positive phase active level, 0 low, 1 high.
// R4 - mode bits 1:0: halt, transfer at crest, at trough, at both.
// R5 - control register clears on reset or standby, not in module standby.
// R6 - control bit 7 enables a/d start on period match and twice-dead-time match.
// R7 - a/d start at trough in mode 1, crest in mode 2, both in mode 3.
// R8 - control bit 6 runs the counters; when clear they hold.
// R9 - lock bit blocks reads except status, writes except buffers/status; reset only clears (the code also clears it on standby).
// R10 - control bit 1 enables dead-time match interrupt while its flag is set.
// R11 - control bit 0 enables period match interrupt while its flag is set.
// R12 - control bits 4 to 2 read zero; write zero only.
// R13 - status register resets to 0x80, not in module standby.
// R14 - status bit 7 shows direction: 1 up, 0 down.
// R15 - status bit 1 sets at twice dead time; cleared by zero write after read.
// R16 - status bit 0 sets at period match; cleared by zero write after read.
// R17 - flags accept only zero writes for clearing; writing one does nothing.
// R18 - counter resets to zero, not in module standby; 16-bit access only.
// R19 - status bits 6 to 2 read zero; write zero only.
// R20 - counting up, period match reverses to down count; this is the crest.
// R21 - counting down, twice dead time reverses to up count; this is the trough.
// R22 - each interrupt is flag AND enable, dropping when either clears.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "mptc_params.svh"

module mptc_timer_control
    import mptc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_standby,
    input wire logic i_module_standby,
    input wire logic [`MPTC_ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_size16,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic [15:0] i_period_data,
    input wire logic [15:0] i_dead_time,
    output logic o_neg_phase_polarity,
    output logic o_pos_phase_polarity,
    output logic [1:0] o_mode,
    output logic o_counter_run,
    output logic o_register_lock,
    output logic o_count_direction_flag,
    output logic [15:0] o_up_down_counter,
    output logic o_crest,
    output logic o_trough,
    output logic o_adc_start,
    output logic o_deadtime_match_irq,
    output logic o_period_match_irq
);

    // ============================================================
    // reset image
    localparam mptc_state_t RESET_STATE = '{
        neg_phase_polarity: 1'b0,
        pos_phase_polarity: 1'b0,
        mode_sel_hi: 1'b0,
        mode_sel_lo: 1'b0,
        adc_trigger_enable: 1'b0,
        counter_run: 1'b0,
        register_lock: 1'b0,
        deadtime_match_irq_enable: 1'b0,
        period_match_irq_enable: 1'b0,
        count_direction_flag: 1'b1,
        deadtime_match_flag: 1'b0,
        period_match_flag: 1'b0,
        deadtime_armed: 1'b0,
        period_armed: 1'b0,
        up_down_counter: `MPTC_CNT_RESET,
        rdata: 16'h0000,
        adc_start: 1'b0,
        crest: 1'b0,
        trough: 1'b0
    };

    mptc_state_t s;
    mptc_state_t next_s;

    // ============================================================
    // helpers

    // hardware set wins over a software clear in the same cycle
    function automatic logic flag_next(input logic flag, input logic set, input logic clr);
        flag_next = set | (flag & ~clr);
    endfunction

    function automatic logic hit(input logic [`MPTC_ADDR_W-1:0] off);
        hit = (i_addr == off);
    endfunction

    logic [16:0] twice_dead;
    logic counting;
    logic period_hit;
    logic dead_hit;
    logic dt_clear;
    logic pd_clear;
    logic counter_load;
    mptc_mode_t mode;
    logic [7:0] control_byte;
    logic [7:0] status_byte;

    assign twice_dead = {i_dead_time, 1'b0};
    assign mode = mptc_mode_t'({s.mode_sel_hi, s.mode_sel_lo}); // [R4]
    assign counting = s.counter_run & ~i_module_standby; // [R8]
    assign period_hit = (s.up_down_counter == i_period_data);
    assign dead_hit = ({1'b0, s.up_down_counter} == twice_dead);
    assign counter_load = i_wr & hit(`MPTC_OFF_COUNTER) & i_size16 & ~s.register_lock; // [R18] [R9]
    // a zero write clears only a flag that was read as one
    assign dt_clear = i_wr & hit(`MPTC_OFF_STATUS) & ~i_wdata[`MPTC_STS_DT_FLAG] & s.deadtime_armed; // [R15] [R17]
    assign pd_clear = i_wr & hit(`MPTC_OFF_STATUS) & ~i_wdata[`MPTC_STS_PD_FLAG] & s.period_armed; // [R16] [R17]

    // reserved bits stay zero on readback
    assign control_byte = {s.adc_trigger_enable, s.counter_run, s.register_lock, 3'h0,
                           s.deadtime_match_irq_enable, s.period_match_irq_enable}; // [R12]
    assign status_byte = {s.count_direction_flag, 5'h00, s.deadtime_match_flag, s.period_match_flag}; // [R19] [R14]

    // ============================================================
    // next state
    always_comb begin
        next_s = s;
        next_s.crest = 1'b0;
        next_s.trough = 1'b0;
        next_s.adc_start = 1'b0;
        next_s.rdata = 16'h0000;

        // up/down count with reversal at period and at twice dead time
        if (counting) begin
            if (s.count_direction_flag) begin
                if (period_hit) begin
                    next_s.count_direction_flag = 1'b0; // [R20]
                    next_s.crest = 1'b1;
                    next_s.up_down_counter = s.up_down_counter - 16'h0001;
                end else begin
                    next_s.up_down_counter = s.up_down_counter + 16'h0001;
                end
            end else begin
                if (dead_hit) begin
                    next_s.count_direction_flag = 1'b1; // [R21]
                    next_s.trough = 1'b1;
                    next_s.up_down_counter = s.up_down_counter + 16'h0001;
                end else begin
                    next_s.up_down_counter = s.up_down_counter - 16'h0001;
                end
            end
        end

        // a/d start: trough in mode 1, crest in mode 2, both in mode 3
        if (s.adc_trigger_enable) begin
            next_s.adc_start = (s.trough & (mode == MPTC_XFER_CREST || mode == MPTC_XFER_BOTH)) |
                               (s.crest & (mode == MPTC_XFER_TROUGH || mode == MPTC_XFER_BOTH)); // [R6] [R7]
        end

        // compare flags
        next_s.deadtime_match_flag = flag_next(s.deadtime_match_flag, counting & dead_hit, dt_clear); // [R15]
        next_s.period_match_flag = flag_next(s.period_match_flag, counting & period_hit, pd_clear); // [R16]
        if (dt_clear || !next_s.deadtime_match_flag) begin
            next_s.deadtime_armed = 1'b0;
        end
        if (pd_clear || !next_s.period_match_flag) begin
            next_s.period_armed = 1'b0;
        end

        // register reads, data stand one cycle later
        if (i_rd) begin
            if (hit(`MPTC_OFF_STATUS)) begin
                next_s.rdata = {8'h00, status_byte};
                if (s.deadtime_match_flag && !dt_clear) begin
                    next_s.deadtime_armed = 1'b1;
                end
                if (s.period_match_flag && !pd_clear) begin
                    next_s.period_armed = 1'b1;
                end
            end else if (!s.register_lock) begin // [R9]
                if (hit(`MPTC_OFF_MODE)) begin
                    next_s.rdata = {12'h000, s.neg_phase_polarity, s.pos_phase_polarity,
                                    s.mode_sel_hi, s.mode_sel_lo};
                end else if (hit(`MPTC_OFF_CONTROL)) begin
                    next_s.rdata = {8'h00, control_byte};
                end else if (hit(`MPTC_OFF_COUNTER) && i_size16) begin
                    next_s.rdata = s.up_down_counter; // [R18]
                end
            end
        end

        // mode and control register writes, blocked once the lock bit is set
        if (i_wr && !s.register_lock) begin // [R9]
            if (hit(`MPTC_OFF_MODE)) begin
                next_s.neg_phase_polarity = i_wdata[`MPTC_MODE_NEG_POL]; // [R2]
                next_s.pos_phase_polarity = i_wdata[`MPTC_MODE_POS_POL]; // [R3]
                next_s.mode_sel_hi = i_wdata[`MPTC_MODE_SEL_HI]; // [R4]
                next_s.mode_sel_lo = i_wdata[`MPTC_MODE_SEL_LO];
            end
            if (hit(`MPTC_OFF_CONTROL)) begin
                next_s.adc_trigger_enable = i_wdata[`MPTC_CTL_ADC_EN]; // [R6]
                next_s.counter_run = i_wdata[`MPTC_CTL_RUN]; // [R8]
                next_s.register_lock = i_wdata[`MPTC_CTL_LOCK];
                next_s.deadtime_match_irq_enable = i_wdata[`MPTC_CTL_DT_IE]; // [R10]
                next_s.period_match_irq_enable = i_wdata[`MPTC_CTL_PD_IE]; // [R11]
            end
        end
        // a software write to the counter overrides the count of that cycle
        if (counter_load) begin
            next_s.up_down_counter = i_wdata;
        end
    end

    // ============================================================
    // state register; module standby resets nothing and only stops the counter
    always_ff @(posedge i_clock) begin
        if (i_reset || i_standby) begin
            s <= RESET_STATE; // [R1] [R5] [R13] [R18]
        end else begin
            s <= next_s;
        end
    end

    // ============================================================
    // outputs
    assign o_rdata = s.rdata;
    assign o_neg_phase_polarity = s.neg_phase_polarity;
    assign o_pos_phase_polarity = s.pos_phase_polarity;
    assign o_mode = {s.mode_sel_hi, s.mode_sel_lo};
    assign o_counter_run = s.counter_run;
    assign o_register_lock = s.register_lock;
    assign o_count_direction_flag = s.count_direction_flag;
    assign o_up_down_counter = s.up_down_counter;
    assign o_crest = s.crest;
    assign o_trough = s.trough;
    assign o_adc_start = s.adc_start;
    assign o_deadtime_match_irq = s.deadtime_match_flag & s.deadtime_match_irq_enable; // [R22] [R10]
    assign o_period_match_irq = s.period_match_flag & s.period_match_irq_enable; // [R22] [R11]

    // ============================================================
    // assertions
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset || i_standby);

    a_lock_holds_control: assert property ( // [R9]
        s.register_lock && i_wr && i_addr == `MPTC_OFF_CONTROL |=> s.register_lock && $stable(s.counter_run)
            && $stable(s.adc_trigger_enable))
        else $error("control register changed while locked");

    a_lock_hides_mode: assert property ( // [R9]
        s.register_lock && i_rd && i_addr == `MPTC_OFF_MODE |=> o_rdata == 16'h0000)
        else $error("mode register readable while locked");

    a_status_readback: assert property ( // [R19]
        i_rd && i_addr == `MPTC_OFF_STATUS |=> o_rdata[15:8] == 8'h00 && o_rdata[6:2] == 5'h00
            && o_rdata[7] == $past(s.count_direction_flag))
        else $error("status readback wrong");

    a_crest_turn: assert property ( // [R20]
        counting && s.count_direction_flag && period_hit && !counter_load
            |=> !s.count_direction_flag && o_crest && s.up_down_counter == $past(s.up_down_counter) - 16'h0001)
        else $error("no reversal at period match");

    a_trough_turn: assert property ( // [R21]
        counting && !s.count_direction_flag && dead_hit && !counter_load
            |=> s.count_direction_flag && o_trough && s.up_down_counter == $past(s.up_down_counter) + 16'h0001)
        else $error("no reversal at twice dead time");

    a_stopped_holds: assert property ( // [R8]
        !s.counter_run && !counter_load |=> $stable(s.up_down_counter) && !o_crest && !o_trough)
        else $error("counter moved while stopped");

    a_flag_set_wins: assert property ( // [R16]
        counting && period_hit |=> s.period_match_flag)
        else $error("period flag not set on match");

    a_flag_needs_read: assert property ( // [R17]
        s.deadtime_match_flag && !s.deadtime_armed |=> s.deadtime_match_flag)
        else $error("dead time flag cleared without prior read");

    a_adc_mode_two: assert property ( // [R7]
        s.adc_trigger_enable && mode == MPTC_XFER_TROUGH && o_trough |=> !o_adc_start)
        else $error("a/d start at trough in mode 2");

    a_adc_from_turn: assert property ( // [R6]
        o_adc_start |-> $past(s.adc_trigger_enable) && ($past(s.crest) || $past(s.trough)))
        else $error("a/d start without a turn point");

    a_irq_drops: assert property ( // [R22]
        $fell(s.period_match_flag) || $fell(s.period_match_irq_enable) |-> !o_period_match_irq)
        else $error("period interrupt stays after clear");

    a_mode_write: assert property ( // [R2] [R3] [R4]
        !s.register_lock && i_wr && i_addr == `MPTC_OFF_MODE
            |=> {o_neg_phase_polarity, o_pos_phase_polarity, o_mode} == $past(i_wdata[3:0]))
        else $error("mode write lost");

    a_control_write: assert property ( // [R6] [R8] [R9]
        !s.register_lock && i_wr && i_addr == `MPTC_OFF_CONTROL
            |=> {s.adc_trigger_enable, o_counter_run, o_register_lock} == $past(i_wdata[7:5]))
        else $error("control write lost");

    a_control_reserved: assert property ( // [R12]
        i_rd && i_addr == `MPTC_OFF_CONTROL |=> o_rdata[15:8] == 8'h00 && o_rdata[4:2] == 3'h0)
        else $error("reserved control bits read nonzero");

    a_lock_hides_all: assert property ( // [R9]
        s.register_lock && i_rd && i_addr != `MPTC_OFF_STATUS |=> o_rdata == 16'h0000)
        else $error("register readable while locked");

    a_lock_freezes: assert property ( // [R9]
        s.register_lock |=> s.register_lock && $stable(o_mode) && $stable(o_counter_run))
        else $error("locked register changed");

    a_short_write: assert property ( // [R18]
        i_wr && i_addr == `MPTC_OFF_COUNTER && !i_size16 && !counting |=> $stable(s.up_down_counter))
        else $error("counter took a narrow write");

    a_counter_load: assert property ( // [R18]
        i_wr && i_addr == `MPTC_OFF_COUNTER && i_size16 && !s.register_lock
            |=> s.up_down_counter == $past(i_wdata))
        else $error("counter write lost");

    a_count_step: assert property ( // [R8]
        counting && !counter_load && !period_hit && !dead_hit |=> s.up_down_counter
            == $past(s.up_down_counter) + ($past(s.count_direction_flag) ? 16'h0001 : 16'hFFFF))
        else $error("counter step wrong");

    a_standby_keeps: assert property ( // [R1] [R5] [R13] [R18]
        i_module_standby && !i_wr |=> $stable(s.up_down_counter) && $stable(s.count_direction_flag)
            && $stable(s.period_match_flag) && $stable(o_mode))
        else $error("state moved in module standby");

    a_dt_flag_set: assert property ( // [R15]
        counting && dead_hit |=> s.deadtime_match_flag)
        else $error("dead time flag not set on match");

    a_zero_clears: assert property ( // [R16] [R17]
        i_wr && i_addr == `MPTC_OFF_STATUS && !i_wdata[`MPTC_STS_PD_FLAG] && s.period_armed
            && !(counting && period_hit) |=> !s.period_match_flag)
        else $error("period flag not cleared");

    a_one_keeps: assert property ( // [R17]
        i_wr && i_addr == `MPTC_OFF_STATUS && i_wdata[`MPTC_STS_DT_FLAG] && !(counting && dead_hit)
            |=> $stable(s.deadtime_match_flag))
        else $error("writing one changed dead time flag");

    a_adc_mode_one: assert property ( // [R7]
        mode == MPTC_XFER_CREST && o_crest |=> !o_adc_start)
        else $error("a/d start at crest in mode 1");

    a_adc_both: assert property ( // [R6] [R7]
        s.adc_trigger_enable && mode == MPTC_XFER_BOTH && (o_crest || o_trough) |=> o_adc_start)
        else $error("a/d start missing in mode 3");

    a_adc_off: assert property ( // [R4] [R6]
        !s.adc_trigger_enable || mode == MPTC_HALT |=> !o_adc_start)
        else $error("a/d start while disabled");

    a_dir_holds: assert property ( // [R14]
        !counting |=> $stable(s.count_direction_flag))
        else $error("direction changed while stopped");

    c_crest: cover property (o_crest);
    c_trough: cover property (o_trough);
    c_adc_start: cover property (o_adc_start);
    c_flag_cleared: cover property ($fell(s.period_match_flag));
    c_locked_write: cover property (s.register_lock && i_wr);

endmodule

/* File: include/mptc_params.svh */
// register offsets, field positions, reset values and sizes of the motor pwm timer control block
`ifndef MPTC_PARAMS_SVH
`define MPTC_PARAMS_SVH

// ============================================================
// register byte offsets
`define MPTC_ADDR_W 8
`define MPTC_OFF_MODE 8'h00
`define MPTC_OFF_CONTROL 8'h02
`define MPTC_OFF_STATUS 8'h04
`define MPTC_OFF_COUNTER 8'h06

// ============================================================
// mode register fields
`define MPTC_MODE_NEG_POL 3
`define MPTC_MODE_POS_POL 2
`define MPTC_MODE_SEL_HI 1
`define MPTC_MODE_SEL_LO 0
`define MPTC_MODE_RESET 4'h0

// ============================================================
// control register fields
`define MPTC_CTL_ADC_EN 7
`define MPTC_CTL_RUN 6
`define MPTC_CTL_LOCK 5
`define MPTC_CTL_DT_IE 1
`define MPTC_CTL_PD_IE 0
`define MPTC_CTL_RESET 8'h00

// ============================================================
// status register fields
`define MPTC_STS_DIR 7
`define MPTC_STS_DT_FLAG 1
`define MPTC_STS_PD_FLAG 0
`define MPTC_STS_RESET 8'h80

// ============================================================
// counter
`define MPTC_CNT_W 16
`define MPTC_CNT_RESET 16'h0000

`endif

/* File: include/mptc_pkg.sv */
// types shared by the motor pwm timer control block
package mptc_pkg;

    // ============================================================
    // operating mode field decode, in field code order
    typedef enum logic [1:0] {
        MPTC_HALT,
        MPTC_XFER_CREST,
        MPTC_XFER_TROUGH,
        MPTC_XFER_BOTH
    } mptc_mode_t;

    // ============================================================
    // whole state of the block
    typedef struct packed {
        logic neg_phase_polarity;
        logic pos_phase_polarity;
        logic mode_sel_hi;
        logic mode_sel_lo;
        logic adc_trigger_enable;
        logic counter_run;
        logic register_lock;
        logic deadtime_match_irq_enable;
        logic period_match_irq_enable;
        logic count_direction_flag;
        logic deadtime_match_flag;
        logic period_match_flag;
        logic deadtime_armed;
        logic period_armed;
        logic [15:0] up_down_counter;
        logic [15:0] rdata;
        logic adc_start;
        logic crest;
        logic trough;
    } mptc_state_t;

endpackage

/* File: tb/mptc_adc_model.sv */
// a/d converter stand-in that counts conversion start requests
`timescale 1ns/1ps
module mptc_adc_model (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_adc_start,
    output int o_starts
);
    // ============================================================
    // conversion start counter
    always @(posedge i_clock) begin
        if (i_reset) begin
            o_starts <= 0;
        end else if (i_adc_start === 1'b1) begin
            o_starts <= o_starts + 1;
        end
    end
endmodule

/* File: tb/testbench.sv */
// self-checking bench of the motor pwm timer control block
`timescale 1ns/1ps
`include "mptc_params.svh"
module testbench;
    logic i_clock, i_reset, i_standby, i_module_standby, i_size16, i_wr, i_rd;
    logic [7:0] i_addr;
    logic [15:0] i_wdata, i_period_data, i_dead_time, o_rdata, o_up_down_counter;
    logic o_neg_phase_polarity, o_pos_phase_polarity, o_counter_run, o_register_lock, o_count_direction_flag;
    logic o_crest, o_trough, o_adc_start, o_deadtime_match_irq, o_period_match_irq;
    logic [1:0] o_mode;
    int fails, compares, starts, cnt, dir, ctl, mode, fl, arm, rdv, crests, troughs, seen_cr, seen_tr;
    int p, d, pa, pd, ps, pwr, prd, m, base;

    mptc_timer_control i_mptc_timer_control (.i_clock(i_clock), .i_reset(i_reset), .i_standby(i_standby),
        .i_module_standby(i_module_standby), .i_addr(i_addr), .i_wdata(i_wdata), .i_size16(i_size16),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_period_data(i_period_data), .i_dead_time(i_dead_time),
        .o_neg_phase_polarity(o_neg_phase_polarity), .o_pos_phase_polarity(o_pos_phase_polarity),
        .o_mode(o_mode), .o_counter_run(o_counter_run), .o_register_lock(o_register_lock),
        .o_count_direction_flag(o_count_direction_flag), .o_up_down_counter(o_up_down_counter),
        .o_crest(o_crest), .o_trough(o_trough), .o_adc_start(o_adc_start),
        .o_deadtime_match_irq(o_deadtime_match_irq), .o_period_match_irq(o_period_match_irq));
    mptc_adc_model i_mptc_adc_model (.i_clock(i_clock), .i_reset(i_reset), .i_adc_start(o_adc_start),
        .o_starts(starts));

    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    // ============================================================
    // checking and bus tasks
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr(input int a, input logic [15:0] v, input logic s);
        @(posedge i_clock);
        i_addr <= 8'(a);
        i_wdata <= v;
        i_size16 <= s;
        i_wr <= 1'b1;
        #3;
        pa = a;
        pd = v;
        ps = s;
        pwr = 1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input int a, input logic s);
        @(posedge i_clock);
        i_addr <= 8'(a);
        i_size16 <= s;
        i_rd <= 1'b1;
        #3;
        pa = a;
        ps = s;
        prd = 1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #3;
        chk("read data", o_rdata, 16'(rdv));
    endtask

    task stop_test;
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ============================================================
    // behavioural model, stepped once per clock
    function automatic int rv(int a, int s);
        if (a == `MPTC_OFF_STATUS) return dir * 128 + fl;
        if (ctl[5]) return 0;
        if (a == `MPTC_OFF_MODE) return mode;
        if (a == `MPTC_OFF_CONTROL) return ctl;
        if (a == `MPTC_OFF_COUNTER && s != 0) return cnt;
        return 0;
    endfunction

    always @(posedge i_clock) begin : model
        int r, ms, s, clr;
        r = i_reset | i_standby;
        ms = i_module_standby;
        #2;
        if (r) begin
            cnt = 0;
            dir = 1;
            ctl = 0;
            mode = 0;
            fl = 0;
            arm = 0;
        end else begin
            s = 0;
            clr = 0;
            if (prd) rdv = rv(pa, ps);
            if (prd && pa == `MPTC_OFF_STATUS) arm |= fl;
            if (ctl[6] && !ms) begin
                if (cnt == p) s |= 1;
                if (cnt == 2 * d) s |= 2;
                if (dir && cnt == p) begin
                    cnt--;
                    dir = 0;
                    crests++;
                end else if (!dir && cnt == 2 * d) begin
                    cnt++;
                    dir = 1;
                    troughs++;
                end else begin
                    cnt = cnt + 2 * dir - 1;
                end
            end
            if (pwr) begin
                case (pa)
                    `MPTC_OFF_MODE: if (!ctl[5]) mode = pd & 15;
                    `MPTC_OFF_CONTROL: if (!ctl[5]) ctl = pd & 8'hE3;
                    `MPTC_OFF_STATUS: clr = arm & ~pd & 3;
                    `MPTC_OFF_COUNTER: if (!ctl[5] && ps) cnt = pd;
                    default: ;
                endcase
            end
            fl = (fl & ~clr) | s;
            arm &= ~clr;
        end
        pwr = 0;
        prd = 0;
    end

    // ============================================================
    // port comparison every cycle while reset is low
    always @(posedge i_clock) begin
        #3;
        if (!i_reset) begin
            chk("counter", o_up_down_counter, 16'(cnt));
            chk("direction", o_count_direction_flag, 16'(dir));
            chk("mode", {o_neg_phase_polarity, o_pos_phase_polarity, o_mode}, 16'(mode));
            chk("run lock", {o_counter_run, o_register_lock}, 16'(ctl[6:5]));
            chk("irqs", {o_deadtime_match_irq, o_period_match_irq}, 16'(fl & ctl[1:0]));
            seen_cr += o_crest;
            seen_tr += o_trough;
        end
    end

    // ============================================================
    // main sequence
    initial begin
        void'($urandom(6481));
        {i_reset, i_standby, i_module_standby, i_size16, i_wr, i_rd} = 6'b100000;
        i_addr = 8'h00;
        i_wdata = 16'h0000;
        d = $urandom % 4;
        p = 2 * d + 6 + $urandom % 10;
        i_dead_time = 16'(d);
        i_period_data = 16'(p);
        repeat (16) @(posedge i_clock);
        i_reset <= 1'b0;
        rd(`MPTC_OFF_MODE, 1);
        rd(`MPTC_OFF_CONTROL, 1);
        rd(`MPTC_OFF_STATUS, 1);
        rd(`MPTC_OFF_COUNTER, 1);
        for (m = 0; m < 5; m++) begin
            wr(`MPTC_OFF_MODE, 16'($urandom % 4 * 4 + m % 4), 1);
            wr(`MPTC_OFF_COUNTER, 16'(2 * d), 1);
            base = starts;
            crests = 0;
            troughs = 0;
            seen_cr = 0;
            seen_tr = 0;
            wr(`MPTC_OFF_CONTROL, m < 4 ? 16'h00DF : 16'h005F, 1);
            rd(`MPTC_OFF_CONTROL, 1);
            repeat (4 * p) begin
                @(posedge i_clock);
                i_module_standby <= ($urandom % 4 == 0);
            end
            @(posedge i_clock);
            i_module_standby <= 1'b0;
            wr(`MPTC_OFF_CONTROL, m < 4 ? 16'h0083 : 16'h0003, 1);
            repeat (4) @(posedge i_clock);
            chk("crests", 16'(seen_cr), 16'(crests));
            chk("troughs", 16'(seen_tr), 16'(troughs));
            chk("starts", 16'(starts - base), 16'((m % 2) * troughs + (m == 2 || m == 3) * crests));
            wr(`MPTC_OFF_STATUS, 16'h0000, 1);
            rd(`MPTC_OFF_STATUS, 1);
            wr(`MPTC_OFF_STATUS, 16'h00FF, 1);
            wr(`MPTC_OFF_STATUS, 16'(m % 3), 1);
            rd(`MPTC_OFF_STATUS, 1);
            rd(`MPTC_OFF_MODE, 1);
            rd(`MPTC_OFF_COUNTER, 1'(m % 2));
        end
        rd(8'h08, 1);
        wr(`MPTC_OFF_COUNTER, 16'h0005, 0);
        wr(`MPTC_OFF_CONTROL, 16'h0020, 1);
        rd(`MPTC_OFF_CONTROL, 1);
        wr(`MPTC_OFF_MODE, 16'h000F, 1);
        rd(`MPTC_OFF_MODE, 1);
        wr(`MPTC_OFF_CONTROL, 16'h0040, 1);
        rd(`MPTC_OFF_STATUS, 1);
        wr(`MPTC_OFF_COUNTER, 16'h1234, 1);
        @(posedge i_clock);
        i_standby <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_standby <= 1'b0;
        rd(`MPTC_OFF_STATUS, 1);
        wr(`MPTC_OFF_CONTROL, 16'h0041, 1);
        rd(`MPTC_OFF_CONTROL, 1);
        stop_test;
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        fails++;
        stop_test;
    end
endmodule
